//--- qsht_defines.vh
// constants shared by the quad serial host target files
`ifndef QSHT_DEFINES_VH
`define QSHT_DEFINES_VH

// host interface modes taken from the boot straps
`define QSHT_MODE_STD   2'h0
`define QSHT_MODE_DUAL  2'h1
`define QSHT_MODE_QUAD  2'h2
`define QSHT_MODE_ETH   2'h3

// frame layout, counted in serial bits; the turnaround is counted in serial clocks
`define QSHT_INSTR_BITS 6'h08
`define QSHT_WORD_BITS  6'h20
`define QSHT_TURN_LAST  6'h01
`define QSHT_READ_BIT   7
`define QSHT_DSEL_BIT   0

// lines driven per mode while answering a read
`define QSHT_LANES_STD  4'h2
`define QSHT_LANES_DUAL 4'h3
`define QSHT_LANES_QUAD 4'hf

// clocks after reset release before the straps are caught
`define QSHT_STRAP_WAIT 2'h3

`endif

//--- qsht_sync.v
// two flop synchroniser for inputs from outside the ref_clk domain
`timescale 1ns/1ps

module qsht_sync #(
  parameter W = 1
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         ce,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end
    else if (ce)
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // qsht_sync

//--- qsht_fifo.v
// message fifo with a registered head word
`timescale 1ns/1ps

module qsht_fifo #(
  parameter W     = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         ce,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output reg  [W-1:0] out_data,
  output reg          out_valid,
  input  wire         out_ready,
  output wire [AW:0]  count
);

  reg  [W-1:0] mem [0:DEPTH-1];
  reg  [AW:0]  wptr_q;
  reg  [AW:0]  rptr_q;
  wire [AW:0]  mem_cnt;
  wire         push;
  wire         fetch;

  // one extra bit on the pointers tells full from empty
  assign mem_cnt  = wptr_q - rptr_q;
  assign in_ready = (mem_cnt != DEPTH[AW:0]);
  assign push     = in_valid & in_ready;
  assign fetch    = (mem_cnt != {(AW+1){1'b0}}) & (~out_valid | out_ready);
  assign count    = mem_cnt + {{AW{1'b0}}, out_valid};

  // storage has no reset, only the pointers and the head register need one
  always @(posedge ref_clk)
  begin
    if (ce & push)
      mem[wptr_q[AW-1:0]] <= in_data;
  end

  // head register refills as soon as it empties
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wptr_q    <= {(AW+1){1'b0}};
      rptr_q    <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {W{1'b0}};
    end
    else if (ce)
    begin
      if (push)
        wptr_q <= wptr_q + 1'b1;
      if (fetch)
      begin
        out_data  <= mem[rptr_q[AW-1:0]];
        out_valid <= 1'b1;
        rptr_q    <= rptr_q + 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end

endmodule // qsht_fifo

//--- qsht_target.v
// serial target port of the host interface, single, dual and quad lines
`timescale 1ns/1ps
`include "qsht_defines.vh"

module qsht_target #(
  parameter WORD_W     = 32,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire              ref_clk,
  input  wire              rst,
  input  wire              ce,
  input  wire              select_n,
  input  wire              serial_clk,
  input  wire [3:0]        serial_line_i,
  output reg  [3:0]        serial_line_o,
  output reg  [3:0]        serial_line_oe,
  input  wire [1:0]        mode_strap,
  input  wire              timer_out,
  output reg               shared_timer_irq_pin_o,
  output wire              shared_timer_irq_pin_oe,
  input  wire [WORD_W-1:0] msg_data,
  input  wire              msg_valid,
  output wire              msg_ready,
  output reg  [WORD_W-1:0] wr_data,
  output reg               wr_valid,
  output wire [1:0]        host_mode
);

  // ****************************************************************
  // frame phases
  // ****************************************************************
  localparam [1:0] PH_INSTR = 2'b00;
  localparam [1:0] PH_TURN  = 2'b01;
  localparam [1:0] PH_RDATA = 2'b10;
  localparam [1:0] PH_WDATA = 2'b11;

  // ****************************************************************
  // pin synchronisers and edge detect
  // ****************************************************************
  wire [7:0]        pins_s;
  wire              ss_s;
  wire              sclk_s;
  wire [3:0]        sio_s;
  wire [1:0]        strap_s;
  reg               sclk_q;
  wire              rise;
  wire              fall;

  qsht_sync #(
    .W (8)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .d       ({mode_strap, serial_line_i, serial_clk, select_n}),
    .q       (pins_s)
  );

  assign ss_s    = pins_s[0];
  assign sclk_s  = pins_s[1];
  assign sio_s   = pins_s[5:2];
  assign strap_s = pins_s[7:6];

  // edges are found on the synchronised clock, never on the raw pin
  assign rise = sclk_s & ~sclk_q;
  assign fall = ~sclk_s & sclk_q;

  // last synchronised clock level; resets to the idle low of the pin
  // so no false edge follows reset
  always @(posedge ref_clk)
  begin
    if (rst)
      sclk_q <= 1'b0;
    else if (ce)
      sclk_q <= sclk_s;
  end

  // ****************************************************************
  // strap capture
  // ****************************************************************
  reg  [1:0] mode_q;
  reg  [1:0] strap_cnt_q;
  reg        strap_done_q;
  wire       eth_mode;
  wire       deselect;

  // straps are read once the synchroniser holds real pin values
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_q       <= `QSHT_MODE_STD;
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
    end
    else if (ce & ~strap_done_q)
    begin
      if (strap_cnt_q == `QSHT_STRAP_WAIT)
      begin
        mode_q       <= strap_s;
        strap_done_q <= 1'b1;
      end
      else
        strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  assign host_mode = mode_q;
  assign eth_mode  = (mode_q == `QSHT_MODE_ETH);

  // ethernet host mode or no straps yet keeps the port deselected
  assign deselect  = ss_s | eth_mode | ~strap_done_q;

  // ****************************************************************
  // per mode line width and lane masks
  // ****************************************************************
  reg  [5:0] lanes_w;
  reg  [3:0] lane_mask;
  reg  [3:0] in_bits;

  // msb of each group sits on the highest active line
  always @*
  begin
    case (mode_q)
      `QSHT_MODE_DUAL:
      begin
        lanes_w   = 6'h02;
        lane_mask = `QSHT_LANES_DUAL;
        in_bits   = {2'b00, sio_s[1:0]};
      end
      `QSHT_MODE_QUAD:
      begin
        lanes_w   = 6'h04;
        lane_mask = `QSHT_LANES_QUAD;
        in_bits   = sio_s;
      end
      default:
      begin
        lanes_w   = 6'h01;
        lane_mask = `QSHT_LANES_STD;
        in_bits   = {3'b000, sio_s[0]};
      end
    endcase
  end

  // ****************************************************************
  // message fifo towards the host
  // ****************************************************************
  wire [WORD_W-1:0]  head_data;
  wire               head_valid;
  wire               head_pop;
  wire [FIFO_AW:0]   fifo_cnt;
  wire [WORD_W-1:0]  len_bytes;

  qsht_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   (msg_data),
    .in_valid  (msg_valid),
    .in_ready  (msg_ready),
    .out_data  (head_data),
    .out_valid (head_valid),
    .out_ready (head_pop),
    .count     (fifo_cnt)
  );

  // every stored word is four bytes of message
  assign len_bytes = {{(WORD_W-FIFO_AW-3){1'b0}}, fifo_cnt, 2'b00};

  // ****************************************************************
  // shift state
  // ****************************************************************
  reg  [1:0]        phase_q;
  reg  [5:0]        cnt_q;
  reg  [WORD_W-1:0] in_q;
  reg  [WORD_W-1:0] out_q;
  reg               dsel_q;
  wire [5:0]        cnt_nx;
  wire [WORD_W-1:0] in_nx;
  wire              instr_end;
  wire              instr_rd;
  wire              word_end;
  wire              load;
  wire              sel_data;
  wire [WORD_W-1:0] load_word;

  assign cnt_nx    = cnt_q + lanes_w;
  assign in_nx     = (in_q << lanes_w) | {{(WORD_W-4){1'b0}}, in_bits};
  assign instr_end = (phase_q == PH_INSTR) & (cnt_nx == `QSHT_INSTR_BITS);
  assign instr_rd  = in_nx[`QSHT_READ_BIT];
  assign word_end  = (cnt_nx == `QSHT_WORD_BITS);

  // standard mode has no turnaround, so its first word loads at once
  assign load = rise & ~deselect &
                ((instr_end & instr_rd & (mode_q == `QSHT_MODE_STD)) |
                 ((phase_q == PH_TURN) & (cnt_q == `QSHT_TURN_LAST)) |
                 ((phase_q == PH_RDATA) & word_end));

  assign sel_data  = (phase_q == PH_INSTR) ? in_nx[`QSHT_DSEL_BIT] : dsel_q;

  // an empty fifo answers zeros rather than stalling the host
  assign load_word = sel_data ? (head_valid ? head_data : {WORD_W{1'b0}})
                              : len_bytes;
  assign head_pop  = load & sel_data & head_valid;

  // ****************************************************************
  // frame sequencer, acts on synchronised serial clock edges
  // ****************************************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      phase_q  <= PH_INSTR;
      cnt_q    <= 6'h00;
      in_q     <= {WORD_W{1'b0}};
      out_q    <= {WORD_W{1'b0}};
      dsel_q   <= 1'b0;
      wr_data  <= {WORD_W{1'b0}};
      wr_valid <= 1'b0;
    end
    else if (ce)
    begin
      wr_valid <= 1'b0;
      if (deselect)
      begin
        // a half word is dropped, next selection starts fresh
        phase_q <= PH_INSTR;
        cnt_q   <= 6'h00;
      end
      else if (rise)
      begin
        case (phase_q)
          PH_INSTR:
          begin
            in_q <= in_nx;
            if (instr_end)
            begin
              cnt_q  <= 6'h00;
              dsel_q <= in_nx[`QSHT_DSEL_BIT];
              if (~instr_rd)
                phase_q <= PH_WDATA;
              else if (mode_q == `QSHT_MODE_STD)
              begin
                phase_q <= PH_RDATA;
                out_q   <= load_word;
              end
              else
              begin
                phase_q <= PH_TURN;
                out_q   <= {WORD_W{1'b0}};
              end
            end
            else
              cnt_q <= cnt_nx;
          end
          PH_TURN:
          begin
            if (cnt_q == `QSHT_TURN_LAST)
            begin
              phase_q <= PH_RDATA;
              cnt_q   <= 6'h00;
              out_q   <= load_word;
            end
            else
              cnt_q <= cnt_q + 6'h01;
          end
          PH_RDATA:
          begin
            // reads run word after word until select rises
            if (word_end)
            begin
              cnt_q <= 6'h00;
              out_q <= load_word;
            end
            else
            begin
              cnt_q <= cnt_nx;
              out_q <= out_q << lanes_w;
            end
          end
          default:
          begin
            in_q <= in_nx;
            if (word_end)
            begin
              cnt_q    <= 6'h00;
              wr_data  <= in_nx;
              wr_valid <= 1'b1;
            end
            else
              cnt_q <= cnt_nx;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // line drivers, updated on falling edges
  // ****************************************************************
  // the host samples on the rising edge, so data moves on the falling
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      serial_line_o  <= 4'h0;
      serial_line_oe <= 4'h0;
    end
    else if (ce)
    begin
      if (deselect)
      begin
        serial_line_o  <= 4'h0;
        serial_line_oe <= 4'h0;
      end
      else if (fall)
      begin
        if ((phase_q == PH_RDATA) | (phase_q == PH_TURN))
          serial_line_oe <= lane_mask;
        else
          serial_line_oe <= 4'h0;
        case (mode_q)
          `QSHT_MODE_QUAD:
            serial_line_o <= out_q[WORD_W-1:WORD_W-4];
          `QSHT_MODE_DUAL:
            serial_line_o <= {2'b00, out_q[WORD_W-1:WORD_W-2]};
          default:
            serial_line_o <= {2'b00, out_q[WORD_W-1], 1'b0};
        endcase
      end
    end
  end

  // ****************************************************************
  // shared timer / interrupt pin
  // ****************************************************************
  // outside ethernet mode the level stays high while words wait, host acts on its rising edge
  always @(posedge ref_clk)
  begin
    if (rst)
      shared_timer_irq_pin_o <= 1'b0;
    else if (ce)
    begin
      if (eth_mode)
        shared_timer_irq_pin_o <= timer_out;
      else
        shared_timer_irq_pin_o <= head_valid;
    end
  end

  // the pin is always an output of this block
  assign shared_timer_irq_pin_oe = 1'b1;

endmodule // qsht_target

//--- qsht_target_asserts.sv
// assertion checker for the quad serial host target port
`timescale 1ns/1ps
`include "qsht_defines.vh"

module qsht_target_asserts (
  input wire       ref_clk,
  input wire       rst,
  input wire       select_n,
  input wire [3:0] serial_line_o,
  input wire [3:0] serial_line_oe,
  input wire [1:0] host_mode,
  input wire       timer_out,
  input wire       shared_timer_irq_pin_o,
  input wire       msg_valid,
  input wire       msg_ready,
  input wire       wr_valid
);
  // ********************
  // properties
  // ********************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // five samples cover the select synchroniser and the oe register
  property p_desel;
    select_n [*5] |-> serial_line_oe == 4'h0;
  endproperty
  a_desel: assert property (p_desel) else $error("driven deselected");
  property p_std;
    host_mode == `QSHT_MODE_STD && serial_line_oe != 4'h0
      |-> serial_line_oe == `QSHT_LANES_STD;
  endproperty
  a_std: assert property (p_std) else $error("std lane set");
  property p_quad;
    host_mode == `QSHT_MODE_QUAD && serial_line_oe != 4'h0
      |-> serial_line_oe == `QSHT_LANES_QUAD;
  endproperty
  a_quad: assert property (p_quad) else $error("quad lane set");
  property p_eth;
    host_mode == `QSHT_MODE_ETH && $past(host_mode) == `QSHT_MODE_ETH
      |-> shared_timer_irq_pin_o == $past(timer_out);
  endproperty
  a_eth: assert property (p_eth) else $error("timer not routed");
  property p_irq;
    host_mode != `QSHT_MODE_ETH && msg_valid && msg_ready
      |-> ##[1:4] shared_timer_irq_pin_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_wr_quiet;
    wr_valid |-> serial_line_oe == 4'h0;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write drove");
  property p_wr_pulse;
    wr_valid |=> !wr_valid [*8];
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("word too soon");
  property p_turn;
    host_mode != `QSHT_MODE_STD && $rose(serial_line_oe[0])
      |-> (serial_line_o & serial_line_oe) == 4'h0;
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround high");
  c_wr: cover property (wr_valid);
  c_irq: cover property ($rose(shared_timer_irq_pin_o));
  c_quad: cover property ($rose(serial_line_oe[3]));
endmodule // qsht_target_asserts

bind qsht_target qsht_target_asserts chk_u (
  .ref_clk, .rst, .select_n, .serial_line_o, .serial_line_oe, .host_mode,
  .timer_out, .shared_timer_irq_pin_o, .msg_valid, .msg_ready, .wr_valid
);

//--- qsht_host_model.sv
// host processor model acting as serial bus controller
`timescale 1ns/1ps

module qsht_host_model (
  input  wire       ref_clk,
  input  wire [3:0] serial_line_o,
  input  wire [3:0] serial_line_oe,
  output logic      select_n = 1'b1,
  output logic      serial_clk = 1'b0,
  output wire [3:0] serial_line_i
);
  // ********************
  // wire level and frames
  // ********************
  logic [3:0]  hen = 4'h0;
  logic [3:0]  hv = 4'h0;
  logic [3:0]  last_q = 4'h0;
  logic [31:0] rd_q[$];
  int          turn_bad = 0;

  // a released line flips every cycle so stale data never passes
  assign serial_line_i = (serial_line_oe & serial_line_o)
    | (~serial_line_oe & hen & hv) | (~serial_line_oe & ~hen & ~last_q);
  always @(posedge ref_clk) last_q <= serial_line_i;

  // one serial clock: drive in the low phase, sample at the rise
  task automatic grp(input int ln, input bit drv,
                     inout logic [31:0] sh, inout logic [31:0] r);
    for (int j = 0; j < ln; j++)
    begin
      hv[(ln == 1) ? 0 : ln - 1 - j] = sh[31];
      sh = sh << 1;
    end
    hen = drv ? 4'((1 << ln) - 1) : 4'h0;
    #400 serial_clk = 1'b1; // 1.25 MHz, far under the limit
    for (int j = 0; j < ln; j++)
      r = {r[30:0], serial_line_i[(ln == 1) ? 1 : ln - 1 - j]};
    #400 serial_clk = 1'b0;
  endtask

  // a whole frame; cut stops a word early to abandon it
  task automatic xfer(input logic [7:0] ins, input int ln, input int nw,
                      input logic [31:0] wd, input int cut);
    logic [31:0] sh;
    logic [31:0] r;
    sh = {ins, 24'h0};
    // pins move a little after the ref_clk edge, never on it
    #7;
    select_n = 1'b0;
    #400;
    repeat (8 / ln) grp(ln, 1'b1, sh, r);
    r = 32'h0;
    if (ins[7] && ln > 1)
    begin
      repeat (2) grp(ln, 1'b0, sh, r);
      if (r !== 32'h0) turn_bad++;
    end
    for (int w = 0; w < nw; w++)
    begin
      sh = wd;
      for (int g = 0; g < 32 / ln && (cut == 0 || g < cut); g++)
        grp(ln, !ins[7], sh, r);
      if (ins[7]) rd_q.push_back(r);
    end
    hen = 4'h0;
    #400 select_n = 1'b1;
    #1200;
  endtask
endmodule // qsht_host_model

//--- tb_top.sv
// self-checking testbench for the quad serial host target port
`timescale 1ns/1ps
`include "qsht_defines.vh"

module tb_top;
  // ********************
  // signals and instances
  // ********************
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [1:0]  mode_strap = 2'h0;
  logic        timer_out = 1'b0;
  logic [31:0] msg_data = 32'h0;
  logic        msg_valid = 1'b0;
  wire         select_n;
  wire         serial_clk;
  wire  [3:0]  line_i;
  wire  [3:0]  line_o;
  wire  [3:0]  line_oe;
  wire         irq_o;
  wire         irq_oe;
  wire         msg_ready;
  wire  [31:0] wr_data;
  wire         wr_valid;
  wire  [1:0]  host_mode;
  logic [31:0] wq[$];
  logic [31:0] mq[$];
  int          err_total = 0;
  int          checked = 0;

  qsht_target dut_u (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .select_n(select_n),
    .serial_clk(serial_clk), .serial_line_i(line_i),
    .serial_line_o(line_o), .serial_line_oe(line_oe),
    .mode_strap(mode_strap), .timer_out(timer_out),
    .shared_timer_irq_pin_o(irq_o), .shared_timer_irq_pin_oe(irq_oe),
    .msg_data(msg_data), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .wr_data(wr_data), .wr_valid(wr_valid), .host_mode(host_mode)
  );
  qsht_host_model host_u (
    .ref_clk(ref_clk), .serial_line_o(line_o), .serial_line_oe(line_oe),
    .select_n(select_n), .serial_clk(serial_clk), .serial_line_i(line_i)
  );

  // clock and a log of every word the host wrote
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wr_valid === 1'b1) wq.push_back(wr_data);

  // ********************
  // tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // straps are set long before release so the capture sees them settled
  task automatic do_reset(input logic [1:0] m);
    @(posedge ref_clk);
    mode_strap <= m;
    rst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    // clock enable low freezes the strap capture at its reset value
    ce <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({30'h0, host_mode}, {30'h0, `QSHT_MODE_STD});
    ce <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk({30'h0, host_mode}, {30'h0, m});
    chk({31'h0, msg_ready}, 32'h1);
    chk({31'h0, irq_oe}, 32'h1);
  endtask

  // valid stays up between words so it is never set twice in a step
  task automatic push_n(input int n, input logic [31:0] base);
    @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      msg_data <= base ^ (32'h0913_5b7d * i);
      msg_valid <= 1'b1;
      mq.push_back(base ^ (32'h0913_5b7d * i));
      do @(posedge ref_clk); while (msg_ready !== 1'b1);
    end
    msg_valid <= 1'b0;
  endtask

  task automatic read_msgs(input int ln);
    int n;
    n = mq.size();
    host_u.xfer(8'h80, ln, 1, 32'h0, 0);
    chk(host_u.rd_q.pop_front(), 32'(n * 4));
    host_u.xfer(8'h81, ln, n, 32'h0, 0);
    repeat (n) chk(host_u.rd_q.pop_front(), mq.pop_front());
  endtask

  task automatic t_mode(input logic [1:0] m, input int ln);
    do_reset(m);
    host_u.xfer(8'h00, ln, 1, 32'ha5c3_1e69, 0);
    chk(32'(wq.size()), 32'h1);
    chk(wq.pop_front(), 32'ha5c3_1e69);
    push_n(2, 32'h8c4e_2a71);
    repeat (6) @(posedge ref_clk);
    chk({31'h0, irq_o}, 32'h1);
    read_msgs(ln);
    chk(32'(host_u.turn_bad), 32'h0);
    repeat (6) @(posedge ref_clk);
    chk({31'h0, irq_o}, 32'h0);
  endtask

  // a word cut short by deselect must leave no trace
  task automatic t_abort;
    host_u.xfer(8'h00, 4, 1, 32'h7e81_c33c, 3);
    host_u.xfer(8'h00, 4, 1, 32'h6b2d_94f0, 0);
    chk(32'(wq.size()), 32'h1);
    chk(wq.pop_front(), 32'h6b2d_94f0);
  endtask

  // sixteen words plus the head fill the buffer; then drain it
  task automatic t_fill;
    push_n(17, 32'h13f7_b906);
    repeat (4) @(posedge ref_clk);
    chk({31'h0, msg_ready}, 32'h0);
    read_msgs(4);
    @(posedge ref_clk);
    chk({31'h0, msg_ready}, 32'h1);
  endtask

  task automatic t_eth;
    do_reset(`QSHT_MODE_ETH);
    timer_out <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq_o}, 32'h1);
    timer_out <= 1'b0;
    push_n(1, 32'h2468_ace1);
    repeat (4) @(posedge ref_clk);
    chk({31'h0, irq_o}, 32'h0);
    host_u.xfer(8'h80, 4, 1, 32'h0, 0);
    host_u.rd_q.delete();
    // the serial port is switched off, so a write must not land
    host_u.xfer(8'h00, 4, 1, 32'h5a5a_0ff0, 0);
    chk(32'(wq.size()), 32'h0);
  endtask

  // ********************
  // main sequence and watchdog
  // ********************
  initial
  begin
    t_mode(`QSHT_MODE_STD, 1);
    t_mode(`QSHT_MODE_DUAL, 2);
    t_mode(`QSHT_MODE_QUAD, 4);
    t_abort;
    t_fill;
    t_eth;
    end_of_test;
  end

  // the run needs well under 1 ms; twice that means a hang
  initial
  begin
    #2_000_000;
    err_total++;
    end_of_test;
  end
endmodule // tb_top
